// file: core/fbg_pkg.sv
package fbg_pkg;
  // divisor register reset values
  localparam logic [7:0] DIV_LOW_RST = 8'h01;
  localparam logic [7:0] DIV_HIGH_RST = 8'h00;
  localparam logic [7:0] DIV_FRAC_RST = 8'h00;
  // modem control prescaler bit
  localparam int MCR_PRESCALE_BIT = 7;
  localparam logic [1:0] PRESCALE_DIV4_LAST = 2'h3;
  // fraction field and sampling select field
  localparam int FRAC_LSB = 0;
  localparam int FRAC_W = 4;
  localparam int SAMP_LSB = 4;
  localparam int SAMP_W = 2;
  localparam logic [1:0] SAMP_16X = 2'h0;
  localparam logic [1:0] SAMP_8X = 2'h1;
  localparam logic [1:0] SAMP_4X = 2'h2;
  localparam logic [4:0] TICKS_16X = 5'h10;
  localparam logic [4:0] TICKS_8X = 5'h08;
  localparam logic [4:0] TICKS_4X = 5'h04;
  // line status bit positions
  localparam int LSR_THR_EMPTY_BIT = 5;
  localparam int LSR_TX_EMPTY_BIT = 6;
  // register addresses on the channel bus
  localparam logic [2:0] ADDR_HOLD = 3'h0;
  localparam logic [2:0] ADDR_DIV_LOW = 3'h0;
  localparam logic [2:0] ADDR_DIV_HIGH = 3'h1;
  localparam logic [2:0] ADDR_DIV_FRAC = 3'h2;
  localparam logic [2:0] ADDR_LINE_CTRL = 3'h3;
  localparam logic [2:0] ADDR_MODEM_CTRL = 3'h4;
  localparam logic [2:0] ADDR_LINE_STATUS = 3'h5;
  localparam logic [7:0] LINE_CTRL_RST = 8'h03;
  localparam int LCR_DLAB_BIT = 7;
  localparam int LCR_STOP_BIT = 2;
  localparam int LCR_PAR_EN_BIT = 3;
  localparam int LCR_PAR_EVEN_BIT = 4;
  localparam int FIFO_DEPTH = 32;
  typedef enum logic [3:0] {
    FBG_IDLE = 4'b0001,
    FBG_START = 4'b0010,
    FBG_DATA = 4'b0100,
    FBG_TAIL = 4'b1000
  } fbg_tx_state_e;
endpackage

// file: core/fbg_fifo.sv
`timescale 1ns/100ps
module fbg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  assign in_ready_o = (cnt_r != DEPTH[AW:0]);
  assign out_valid_o = (cnt_r != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_r];
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_r] <= in_data_i;
    end
  end
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// file: core/fbg_tx.sv
`timescale 1ns/100ps
module fbg_tx #(
  parameter int FIFO_WORDS = fbg_pkg::FIFO_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic bus_cs_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [2:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  output logic [7:0] bus_rdata_o,
  output logic tx_data_o,
  output logic sample_tick_o,
  output logic holding_ready_o
);
  logic [7:0] div_low_r;
  logic [7:0] div_high_r;
  logic [7:0] div_frac_r;
  logic [7:0] line_ctrl_r;
  logic [7:0] modem_control_reg;
  logic wr_en;
  logic rd_en;
  logic dlab;
  logic hold_push;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [7:0] fifo_out_data;
  logic [1:0] pre_cnt_r;
  logic pre_tick;
  logic [15:0] base_cnt_r;
  logic [3:0] frac_phase_r;
  logic stretch_r;
  logic samp_tick_r;
  logic [3:0] div_fraction;
  logic [1:0] samp_sel;
  logic [4:0] bit_ticks;
  logic [4:0] tick_cnt_r;
  logic bit_end;
  fbg_pkg::fbg_tx_state_e state_r;
  logic [7:0] shift_r;
  logic [2:0] bit_idx_r;
  logic [1:0] tail_idx_r;
  logic parity_r;
  logic [7:0] line_status;
  logic [15:0] div_int;
  logic div_wrap;
  logic tail_last;

  // odd fraction jitter
  // fractional phase select: spreads extra cycles evenly over 16 periods
  function automatic logic frac_hit(input logic [3:0] phase, input logic [3:0] frac);
    logic [3:0] rev;
    rev = {phase[0], phase[1], phase[2], phase[3]};
    return rev < frac;
  endfunction

  function automatic logic [4:0] ticks_of(input logic [1:0] sel);
    case (sel)
      fbg_pkg::SAMP_8X: return fbg_pkg::TICKS_8X;
      fbg_pkg::SAMP_4X: return fbg_pkg::TICKS_4X;
      default: return fbg_pkg::TICKS_16X;
    endcase
  endfunction

  assign dlab = line_ctrl_r[fbg_pkg::LCR_DLAB_BIT];
  assign wr_en = bus_cs_i && bus_wr_i;
  assign rd_en = bus_cs_i && bus_rd_i;
  assign hold_push = wr_en && !dlab && (bus_addr_i == fbg_pkg::ADDR_HOLD);
  assign div_fraction = div_frac_r[fbg_pkg::FRAC_LSB +: fbg_pkg::FRAC_W];
  assign samp_sel = div_frac_r[fbg_pkg::SAMP_LSB +: fbg_pkg::SAMP_W];
  assign bit_ticks = ticks_of(samp_sel);

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_low_r <= fbg_pkg::DIV_LOW_RST;
      div_high_r <= fbg_pkg::DIV_HIGH_RST;
      div_frac_r <= fbg_pkg::DIV_FRAC_RST;
      line_ctrl_r <= fbg_pkg::LINE_CTRL_RST;
      modem_control_reg <= '0;
    end else if (wr_en) begin
      if (dlab && bus_addr_i == fbg_pkg::ADDR_DIV_LOW) begin
        div_low_r <= bus_wdata_i;
      end
      if (dlab && bus_addr_i == fbg_pkg::ADDR_DIV_HIGH) begin
        div_high_r <= bus_wdata_i;
      end
      if (dlab && bus_addr_i == fbg_pkg::ADDR_DIV_FRAC) begin
        div_frac_r <= bus_wdata_i;
      end
      if (bus_addr_i == fbg_pkg::ADDR_LINE_CTRL) begin
        line_ctrl_r <= bus_wdata_i;
      end
      if (bus_addr_i == fbg_pkg::ADDR_MODEM_CTRL) begin
        modem_control_reg <= bus_wdata_i;
      end
    end
  end

  // status bits from fifo and shifter
  always_comb begin
    line_status = '0;
    line_status[fbg_pkg::LSR_THR_EMPTY_BIT] = !fifo_out_valid;
    line_status[fbg_pkg::LSR_TX_EMPTY_BIT] = !fifo_out_valid && (state_r == fbg_pkg::FBG_IDLE);
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_rdata_o <= '0;
    end else if (rd_en) begin
      case (bus_addr_i)
        fbg_pkg::ADDR_DIV_LOW: bus_rdata_o <= dlab ? div_low_r : 8'h00;
        fbg_pkg::ADDR_DIV_HIGH: bus_rdata_o <= dlab ? div_high_r : 8'h00;
        fbg_pkg::ADDR_DIV_FRAC: bus_rdata_o <= dlab ? div_frac_r : 8'h00;
        fbg_pkg::ADDR_LINE_CTRL: bus_rdata_o <= line_ctrl_r;
        fbg_pkg::ADDR_MODEM_CTRL: bus_rdata_o <= modem_control_reg;
        fbg_pkg::ADDR_LINE_STATUS: bus_rdata_o <= line_status;
        default: bus_rdata_o <= 8'h00;
      endcase
    end
  end

  // prescaler, divide by one or four
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pre_cnt_r <= '0;
    end else if (modem_control_reg[fbg_pkg::MCR_PRESCALE_BIT]) begin
      pre_cnt_r <= pre_cnt_r + 1'b1;
    end else begin
      pre_cnt_r <= '0;
    end
  end
  assign pre_tick = !modem_control_reg[fbg_pkg::MCR_PRESCALE_BIT] || (pre_cnt_r == fbg_pkg::PRESCALE_DIV4_LAST);

  // integer from high and low bytes
  assign div_int = {div_high_r, div_low_r};
  // period end; zero integer acts as 65536
  // a count already past a lowered divisor ends at once, no 65536 wrap
  assign div_wrap = (base_cnt_r == div_int - 16'h0001) || ((div_int != 16'h0000) && (base_cnt_r >= div_int));
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      base_cnt_r <= '0;
      frac_phase_r <= '0;
      stretch_r <= 1'b0;
      samp_tick_r <= 1'b0;
    end else begin
      samp_tick_r <= 1'b0;
      if (pre_tick) begin
        if (stretch_r) begin
          stretch_r <= 1'b0;
          samp_tick_r <= 1'b1;
          base_cnt_r <= '0;
          frac_phase_r <= frac_phase_r + 1'b1;
        end else if (div_wrap) begin
          base_cnt_r <= '0;
          if (frac_hit(frac_phase_r, div_fraction)) begin
            stretch_r <= 1'b1;
          end else begin
            samp_tick_r <= 1'b1;
            frac_phase_r <= frac_phase_r + 1'b1;
          end
        end else begin
          base_cnt_r <= base_cnt_r + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sample_tick_o <= 1'b0;
    end else begin
      sample_tick_o <= samp_tick_r;
    end
  end

  fbg_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_WORDS)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(hold_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(bus_wdata_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      holding_ready_o <= 1'b0;
    end else begin
      holding_ready_o <= fifo_in_ready;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_cnt_r <= '0;
    end else if (state_r == fbg_pkg::FBG_IDLE) begin
      tick_cnt_r <= '0;
    end else if (samp_tick_r) begin
      tick_cnt_r <= bit_end ? 5'h00 : tick_cnt_r + 1'b1;
    end
  end
  assign bit_end = samp_tick_r && (tick_cnt_r + 5'h01 == bit_ticks);
  // start on a tick
  // otherwise the start bit is short by up to one sampling period
  assign fifo_pop = (state_r == fbg_pkg::FBG_IDLE) && fifo_out_valid && samp_tick_r;
  assign tail_last = (tail_idx_r ==
    {1'b0, line_ctrl_r[fbg_pkg::LCR_STOP_BIT]} + 2'(line_ctrl_r[fbg_pkg::LCR_PAR_EN_BIT]));

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= fbg_pkg::FBG_IDLE;
      shift_r <= '0;
      bit_idx_r <= '0;
      tail_idx_r <= '0;
      parity_r <= 1'b0;
      tx_data_o <= 1'b1;
    end else begin
      case (state_r)
        fbg_pkg::FBG_IDLE: begin
          tx_data_o <= 1'b1;
          if (fifo_out_valid && samp_tick_r) begin
            shift_r <= fifo_out_data;
            parity_r <= !line_ctrl_r[fbg_pkg::LCR_PAR_EVEN_BIT];
            bit_idx_r <= '0;
            tx_data_o <= 1'b0;
            state_r <= fbg_pkg::FBG_START;
          end
        end
        fbg_pkg::FBG_START: begin
          if (bit_end) begin
            tx_data_o <= shift_r[0];
            parity_r <= parity_r ^ shift_r[0];
            shift_r <= {1'b0, shift_r[7:1]};
            state_r <= fbg_pkg::FBG_DATA;
          end
        end
        fbg_pkg::FBG_DATA: begin
          if (bit_end) begin
            if (bit_idx_r == {1'b1, line_ctrl_r[1:0]}) begin
              tail_idx_r <= '0;
              state_r <= fbg_pkg::FBG_TAIL;
              tx_data_o <= line_ctrl_r[fbg_pkg::LCR_PAR_EN_BIT] ? parity_r : 1'b1;
            end else begin
              tx_data_o <= shift_r[0];
              parity_r <= parity_r ^ shift_r[0];
              shift_r <= {1'b0, shift_r[7:1]};
            end
            bit_idx_r <= bit_idx_r + 1'b1;
          end
        end
        fbg_pkg::FBG_TAIL: begin
          if (bit_end) begin
            tx_data_o <= 1'b1;
            tail_idx_r <= tail_idx_r + 1'b1;
            if (tail_last) begin
              state_r <= fbg_pkg::FBG_IDLE;
            end
          end
        end
        default: begin
          state_r <= fbg_pkg::FBG_IDLE;
        end
      endcase
    end
  end
endmodule

// file: tb/fbg_tx_monitor.sv
`timescale 1ns/100ps
module fbg_tx_checker (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic bus_cs_i,
  input wire logic bus_rd_i,
  input wire logic [2:0] bus_addr_i,
  input wire logic [7:0] bus_rdata_o,
  input wire logic tx_data_o,
  input wire logic sample_tick_o,
  input wire logic holding_ready_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  logic st_rd;
  assign st_rd = bus_cs_i && bus_rd_i && bus_addr_i == 3'h5;
  property p_idle; $rose(resetn_i) |-> tx_data_o; endproperty
  a_idle: assert property (p_idle) else $error("line not idle");
  property p_room; $rose(resetn_i) |-> ##[0:3] holding_ready_o; endproperty
  a_room: assert property (p_room) else $error("no room");
  property p_tick; $rose(resetn_i) |-> ##[0:8] sample_tick_o; endproperty
  a_tick: assert property (p_tick) else $error("no tick");
  property p_low; $fell(tx_data_o) |-> !tx_data_o [*4]; endproperty
  a_low: assert property (p_low) else $error("low bit short");
  property p_high; $rose(tx_data_o) |-> tx_data_o [*4]; endproperty
  a_high: assert property (p_high) else $error("high bit short");
  property p_busy; st_rd && !tx_data_o |-> ##2 !bus_rdata_o[6]; endproperty
  a_busy: assert property (p_busy) else $error("idle mid frame");
  property p_full; st_rd && !holding_ready_o && $past(resetn_i) |-> ##2 !bus_rdata_o[5]; endproperty
  a_full: assert property (p_full) else $error("empty while full");
  property p_order; st_rd |-> ##2 (!bus_rdata_o[6] || bus_rdata_o[5]); endproperty
  a_order: assert property (p_order) else $error("status order");
  c_frame: cover property ($fell(tx_data_o));
  c_full: cover property (st_rd && !holding_ready_o);
  c_busy: cover property (st_rd && !tx_data_o);
endmodule
bind fbg_tx fbg_tx_checker u_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .bus_cs_i(bus_cs_i),
  .bus_rd_i(bus_rd_i), .bus_addr_i(bus_addr_i), .bus_rdata_o(bus_rdata_o), .tx_data_o(tx_data_o),
  .sample_tick_o(sample_tick_o), .holding_ready_o(holding_ready_o));

// file: tb/fbg_rx_model.sv
`timescale 1ns/100ps
module fbg_rx_model (
  input wire logic core_clk_i,
  input wire logic line_i,
  input wire logic [31:0] bt16_i,
  input wire logic [3:0] nbits_i,
  input wire logic par_en_i,
  output logic [7:0] rx_byte_o,
  output logic rx_par_o,
  output logic rx_stop_o,
  output logic rx_done_o
);
  int c;
  initial begin
    rx_done_o = 1'b0;
    forever begin
      @(negedge line_i);
      c = 0;
      rx_byte_o = 8'h00;
      // mid-bit sampling tolerates fraction jitter
      for (int j = 1; j <= nbits_i + par_en_i + 1; j++) begin
        while (c < ((2 * j + 1) * bt16_i) / 32) begin
          @(negedge core_clk_i);
          c++;
        end
        if (j <= nbits_i) rx_byte_o[j - 1] = line_i;
        else if (par_en_i && j == nbits_i + 1) rx_par_o = line_i;
        else rx_stop_o = line_i;
      end
      rx_done_o = 1'b1;
      @(negedge core_clk_i);
      rx_done_o = 1'b0;
    end
  end
endmodule

// file: tb/tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, rx_byte, ev, rv;
  logic txd, tick, ready, rx_par, rx_stop, rx_done;
  logic par_en = 1'b0;
  logic par_even = 1'b0;
  logic [3:0] nbits = 4'h8;
  logic [31:0] bt16 = 32'h0000_0100;
  logic [7:0] expq[$];
  logic [7:0] cfg[4][4] = '{'{8'h01, 8'h00, 8'h00, 8'h03}, '{8'h02, 8'h13, 8'h80, 8'h0a},
    '{8'h03, 8'h28, 8'h00, 8'h00}, '{8'h01, 8'h25, 8'h00, 8'h1f}};
  int num_errors = 0;
  int total_checks = 0;
  int seed = 32'h175a_2c5b;
  int sp;
  fbg_tx uut (.core_clk_i(clk), .resetn_i(rst_n), .bus_cs_i(cs), .bus_wr_i(wr), .bus_rd_i(rd),
    .bus_addr_i(addr), .bus_wdata_i(wdata), .bus_rdata_o(rdata), .tx_data_o(txd),
    .sample_tick_o(tick), .holding_ready_o(ready));
  fbg_rx_model rx (.core_clk_i(clk), .line_i(txd), .bt16_i(bt16), .nbits_i(nbits), .par_en_i(par_en),
    .rx_byte_o(rx_byte), .rx_par_o(rx_par), .rx_stop_o(rx_stop), .rx_done_o(rx_done));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic bound(input int c, input int lim);
    if (c > lim) begin
      num_errors++;
      final_report();
    end
  endtask
  // registered read data lands before cs drops; extra idle edge only spaces accesses
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    cs = 1'b1;
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(negedge clk);
    cs = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    @(negedge clk);
  endtask
  task automatic chk_reg(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(rdata & m, e)
  endtask
  task automatic setup(input int k);
    bus(1'b1, 3'h3, 8'h80 | cfg[k][3]);
    bus(1'b1, 3'h0, cfg[k][0]);
    bus(1'b1, 3'h1, 8'h00);
    bus(1'b1, 3'h2, cfg[k][1]);
    bus(1'b1, 3'h4, cfg[k][2]);
    bus(1'b1, 3'h3, cfg[k][3]);
    sp = (cfg[k][2][7] ? 4 : 1) * (16 * cfg[k][0] + cfg[k][1][3:0]);
    bt16 = sp * (16 >> cfg[k][1][5:4]);
    nbits = 4'h5 + cfg[k][3][1:0];
    par_en = cfg[k][3][3];
    par_even = cfg[k][3][4];
  endtask
  // sixteen periods hold every fraction phase once
  task automatic span(input int e);
    int c;
    int t;
    c = 0;
    t = 0;
    while (tick !== 1'b1) begin
      @(negedge clk);
      c++;
      bound(c, 3000);
    end
    c = 0;
    while (t < 16) begin
      @(negedge clk);
      c++;
      if (tick === 1'b1) t++;
      bound(c, 5000);
    end
    `CHK(c, e)
  endtask
  task automatic send(input int nb);
    logic [7:0] d;
    for (int i = 0; i < nb; i++) begin
      d = $random(seed);
      bus(1'b1, 3'h0, d);
      if (i < 33) expq.push_back(d & (8'hff >> (8 - nbits)));
    end
  endtask
  task automatic drain();
    int c;
    c = 0;
    bus(1'b0, 3'h5, 8'h00);
    while (rdata[6] !== 1'b1) begin
      c++;
      bound(c, 4000);
      bus(1'b0, 3'h5, 8'h00);
    end
    `CHK(expq.size(), 0)
    `CHK(rdata[6:5], 2'b11)
  endtask
  always @(posedge rx_done) begin
    `CHK(expq.size() > 0, 1'b1)
    ev = expq.pop_front();
    `CHK(rx_byte, ev)
    `CHK(rx_stop, 1'b1)
    if (par_en) `CHK(rx_par, par_even ? ^ev : ~^ev)
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    chk_reg(3'h5, 8'h60, 8'h60);
    bus(1'b1, 3'h3, 8'h83);
    chk_reg(3'h0, 8'hff, 8'h01);
    chk_reg(3'h1, 8'hff, 8'h00);
    chk_reg(3'h2, 8'hff, 8'h00);
    chk_reg(3'h7, 8'hff, 8'h00);
    // high byte kept small so the running count stays short
    rv = $random(seed);
    bus(1'b1, 3'h0, rv);
    bus(1'b1, 3'h1, {7'h00, rv[0]});
    chk_reg(3'h0, 8'hff, rv);
    chk_reg(3'h1, 8'hff, {7'h00, rv[0]});
    $display("test regs done");
    for (int k = 0; k < 4; k++) begin
      setup(k);
      span(sp);
      send(5);
      drain();
      $display("test cfg %0d done", k);
    end
    setup(0);
    send(34);
    `CHK(ready, 1'b0)
    chk_reg(3'h5, 8'h20, 8'h00);
    drain();
    $display("test fill done");
    final_report();
  end
endmodule
